// ---- bench/upsm_host_model.sv ----
// host model: usb host events and suspend select writes from the driver
// assumes: tb calls its tasks; outputs change 1 ns after the rising edge
`timescale 1ns/100ps
module upsm_host_model (
   input  wire logic i_sys_clk,
   output logic [4:0] o_ev,
   output logic       o_sel_wr,
   output logic [1:0] o_sel_wdata
);
   initial begin
      o_ev        = 5'h00;
      o_sel_wr    = 1'b0;
      o_sel_wdata = 2'h0;
   end
   // event index: 0 reset, 1 config, 2 deconfig, 3 suspend, 4 resume
   task automatic pulse(input int k);
      @(posedge i_sys_clk);
      #1 o_ev[k] = 1'b1;
      @(posedge i_sys_clk);
      #1 o_ev[k] = 1'b0;
   endtask
   task automatic suspend(input logic [1:0] lv);
      @(posedge i_sys_clk);
      #1 o_sel_wr = 1'b1;
      o_sel_wdata = lv;
      @(posedge i_sys_clk);
      #1 o_sel_wr = 1'b0;
      o_sel_wdata = ~lv;
      pulse(3);
   endtask
endmodule

// ---- bench/upsm_power_manager_properties.sv ----
// checker: power state transitions seen at the power manager ports
// assumes: bound to upsm_power_manager, one clock, async low reset
`timescale 1ns/100ps
module upsm_power_manager_properties
   import upsm_pkg::*;
(
   input wire logic                 i_sys_clk,
   input wire logic                 i_arst_n,
   input wire logic                 i_bus_power_detect,
   input wire logic                 i_pin_reset_n,
   input wire logic                 i_usb_reset,
   input wire logic                 i_usb_configured,
   input wire logic                 i_usb_deconfigured,
   input wire logic                 i_usb_suspend,
   input wire logic                 i_usb_resume,
   input wire logic [UPSM_WK_W-1:0] i_wake_evt,
   input wire logic [UPSM_WK_W-1:0] i_wake_en,
   input wire logic                 o_ready,
   input wire logic [1:0]           o_suspend_sel,
   input wire logic [UPSM_EN_W-1:0] o_module_en,
   input wire logic [7:0]           o_state,
   input wire logic                 o_hw_reinit
);
   ////////////////////////////////////////////////////////////////////
   // pins pass a 2-flop sync, so a reset or power loss counts 3 back
   logic [2:0] ok_sr;
   logic       calm;
   logic       quiet;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ok_sr <= 3'h0;
      end else begin
         ok_sr <= {ok_sr[1:0], i_bus_power_detect & i_pin_reset_n};
      end
   end
   assign calm  = (&ok_sr) & i_bus_power_detect & i_pin_reset_n;
   assign quiet = calm & ~i_usb_reset & ~i_usb_deconfigured;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);
   sequence s_susp(logic [7:0] st, logic [1:0] sl);
      o_state == st && o_suspend_sel == sl && i_usb_suspend && quiet;
   endsequence
   sequence s_ev(logic [7:0] st, logic ev);
      o_state == st && ev && quiet;
   endsequence
   ////////////////////////////////////////////////////////////////////
   ready_decode_a: assert property (
      o_ready == (o_state inside {UPSM_ST_UNCFG, UPSM_ST_CFG}))
      else $error("ready does not follow normal state");
   enable_decode_a: assert property (o_module_en ==
      (o_state == UPSM_ST_CFG ? UPSM_EN_FULL :
       o_state == UPSM_ST_UNCFG ? UPSM_EN_REDUCE : UPSM_EN_NONE))
      else $error("module enables wrong for state");
   cfg_entry_a: assert property (
      s_ev(UPSM_ST_UNCFG, i_usb_configured) |=> o_state == UPSM_ST_CFG)
      else $error("configure did not reach configured");
   deconfig_sel_a: assert property (
      o_state == UPSM_ST_CFG && i_usb_deconfigured && calm && !i_usb_reset
      |=> o_state == UPSM_ST_UNCFG && o_suspend_sel == UPSM_SEL_RST)
      else $error("deconfigure did not restore unconfigured");
   susp_level0_a: assert property (
      s_susp(UPSM_ST_CFG, UPSM_SEL_L0) |=> o_state == UPSM_ST_SUS0)
      else $error("select 0 suspend missed level 0");
   susp_level1_a: assert property (
      s_susp(UPSM_ST_CFG, UPSM_SEL_L1) |=> o_state == UPSM_ST_SUS1)
      else $error("select 1 suspend missed level 1");
   susp_uncfg_a: assert property (
      s_ev(UPSM_ST_UNCFG, i_usb_suspend) |=> o_state == UPSM_ST_SUS2U)
      else $error("unconfigured suspend missed level 2");
   no_cfg_return_a: assert property (
      o_state == UPSM_ST_SUS2U |=> o_state != UPSM_ST_CFG)
      else $error("level 2 from unconfigured reached configured");
   host_resume_a: assert property (
      o_state inside {UPSM_ST_SUS0, UPSM_ST_SUS1} && i_usb_resume && quiet
      |=> o_state == UPSM_ST_CFG)
      else $error("resume from level 0 or 1 refused");
   level2_hold_a: assert property (
      s_ev(UPSM_ST_SUS2, !i_usb_resume) and
      s_ev(UPSM_ST_SUS2, !(i_wake_evt[UPSM_WK_GPIO] & i_wake_en[0]))
      |=> o_state == UPSM_ST_SUS2)
      else $error("level 2 left without resume or pin wake");
   susp_reset_a: assert property (
      o_state inside {UPSM_ST_SUS0, UPSM_ST_SUS1, UPSM_ST_SUS2,
      UPSM_ST_SUS3, UPSM_ST_SUS2U} && i_usb_reset && calm
      |=> o_state == UPSM_ST_UNCFG && o_hw_reinit)
      else $error("usb reset in suspend not handled");
   power_loss_a: assert property (
      $fell(i_bus_power_detect) |-> ##[1:3] o_state == UPSM_ST_UNPOW)
      else $error("bus power loss did not reach unpowered");
endmodule

// ---- bench/upsm_power_manager_tb.sv ----
// testbench: power state walk of the usb power manager
// assumes: host model drives usb events, bench drives pins and wakes
`timescale 1ns/100ps
module upsm_power_manager_tb
   import upsm_pkg::*;
;
   logic clk = 1'b0, arst_n = 1'b0, bp, pin_n, l7;
   logic [4:0] ev, wevt, wen, w;
   logic sel_wr, ready, lost, flag, reinit;
   logic [1:0] sel_wd, sel;
   logic [3:0] en;
   logic [7:0] st, last, e;
   logic [7:0] exp_q[$];
   logic [7:0] st_of[4] = '{8'h08, 8'h10, 8'h20, 8'h40};
   logic [4:0] bad[4] = '{5'h18, 5'h16, 5'h1E, 5'h0A};
   logic [4:0] good[4] = '{5'h02, 5'h08, 5'h01, 5'h10};
   int err_count = 0, n_tests = 0, r, k;
   always #20 clk = ~clk;
   upsm_host_model u_upsm_host_model (.i_sys_clk(clk), .o_ev(ev),
      .o_sel_wr(sel_wr), .o_sel_wdata(sel_wd));
   upsm_power_manager u_upsm_power_manager (
      .i_sys_clk(clk), .i_arst_n(arst_n), .i_bus_power_detect(bp),
      .i_pin_reset_n(pin_n), .i_gpio7_link_up(l7), .i_usb_reset(ev[0]),
      .i_usb_configured(ev[1]), .i_usb_deconfigured(ev[2]),
      .i_usb_suspend(ev[3]), .i_usb_resume(ev[4]), .i_sel_wr(sel_wr),
      .i_sel_wdata(sel_wd), .i_wake_evt(wevt), .i_wake_en(wen),
      .o_ready(ready), .o_suspend_sel(sel), .o_module_en(en),
      .o_phy_lost(lost), .o_link_up_wake_flag(flag), .o_state(st),
      .o_hw_reinit(reinit));
   ////////////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      err_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk(input logic c, input string m);
      n_tests++;
      if (c !== 1'b1) fail(m);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // bounded wait until every noted state change was seen
   task automatic settle(input string s);
      for (int i = 0; i < 30 && exp_q.size() > 0; i++) @(posedge clk);
      #1;
      if (exp_q.size() > 0) begin
         fail("state change timed out");
         give_verdict();
      end
      if (s != "") $display("end of %s", s);
   endtask
   // scoreboard: each change of state takes the oldest note
   always @(negedge clk) begin
      if (!arst_n) last = st;
      else if (st !== last) begin
         last = st;
         n_tests++;
         if (exp_q.size() == 0) fail("unexpected state change");
         else begin
            e = exp_q.pop_front();
            if (st !== e) fail("wrong state");
            if (ready !== (e == UPSM_ST_UNCFG || e == UPSM_ST_CFG))
               fail("wrong ready");
            if (en !== (e == UPSM_ST_CFG ? UPSM_EN_FULL :
               e == UPSM_ST_UNCFG ? UPSM_EN_REDUCE : UPSM_EN_NONE))
               fail("wrong module enables");
            if (lost !== (e == UPSM_ST_SUS2 || e == UPSM_ST_SUS2U))
               fail("wrong phy lost");
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h4E3B));
      bp = 1'b0;
      pin_n = 1'b1;
      l7 = 1'b1;
      wevt = 5'h00;
      wen = 5'h1F;
      repeat (5) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk(st === UPSM_ST_UNPOW, "left unpowered without power");
      exp_q.push_back(UPSM_ST_UNCFG);
      bp = 1'b1;
      settle("power up");
      exp_q.push_back(UPSM_ST_CFG);
      u_upsm_host_model.pulse(1);
      settle("configure");
      for (int i = 0; i < 8; i++) begin
         k = i % 4;
         r = (i < 4) ? (k + 2) % 3 : $urandom % 3;
         // random enables and link level; the chosen wake stays enabled
         w = (r == 1) ? 5'h01 : good[k];
         wen = 5'($urandom) | w;
         l7 = 1'($urandom);
         exp_q.push_back(st_of[k]);
         u_upsm_host_model.suspend(k[1:0]);
         settle("");
         chk(sel === k[1:0], "select not kept");
         wevt = bad[k];
         repeat (4) @(posedge clk);
         #1 wevt = 5'h00;
         exp_q.push_back(UPSM_ST_CFG);
         if (r == 0) u_upsm_host_model.pulse(4);
         else wevt = w;
         settle("suspend level");
         wevt = 5'h00;
         chk(flag === (r != 0 && w[0] && l7 && wen[2]),
             "link wake flag wrong");
      end
      exp_q.push_back(UPSM_ST_UNCFG);
      u_upsm_host_model.pulse(2);
      settle("deconfigure");
      chk(sel === UPSM_SEL_RST, "select not reset");
      exp_q.push_back(UPSM_ST_SUS2U);
      u_upsm_host_model.suspend(UPSM_SEL_L0);
      exp_q.push_back(UPSM_ST_UNCFG);
      u_upsm_host_model.pulse(4);
      settle("unconfigured suspend");
      exp_q.push_back(UPSM_ST_SUS2U);
      u_upsm_host_model.suspend(UPSM_SEL_L0);
      exp_q.push_back(UPSM_ST_UNCFG);
      u_upsm_host_model.pulse(0);
      chk(reinit === 1'b1, "no reinit after usb reset");
      settle("usb reset");
      exp_q.push_back(UPSM_ST_CFG);
      u_upsm_host_model.pulse(1);
      exp_q.push_back(UPSM_ST_SUS1);
      u_upsm_host_model.suspend(UPSM_SEL_L1);
      settle("");
      exp_q.push_back(UPSM_ST_UNCFG);
      pin_n = 1'b0;
      settle("pin reset");
      pin_n = 1'b1;
      // pin release needs the two sync stages before configure counts
      repeat (3) @(posedge clk);
      #1;
      exp_q.push_back(UPSM_ST_CFG);
      u_upsm_host_model.pulse(1);
      exp_q.push_back(UPSM_ST_UNPOW);
      bp = 1'b0;
      settle("");
      exp_q.push_back(UPSM_ST_UNCFG);
      bp = 1'b1;
      settle("power loss");
      give_verdict();
   end
endmodule
bind upsm_power_manager upsm_power_manager_properties u_props (.*);

// ---- core/upsm_pkg.sv ----
// upsm_pkg: states, encodings and field constants for the power manager
// assumes: a single 25 MHz clock domain shared by every design file
package upsm_pkg;

   // suspend select field encodings
   localparam logic [1:0] UPSM_SEL_L0    = 2'h0;
   localparam logic [1:0] UPSM_SEL_L1    = 2'h1;
   localparam logic [1:0] UPSM_SEL_L2    = 2'h2;
   localparam logic [1:0] UPSM_SEL_L3    = 2'h3;
   localparam logic [1:0] UPSM_SEL_RST   = UPSM_SEL_L2;

   // module enable vector layout
   localparam int         UPSM_EN_W      = 4;
   localparam logic [3:0] UPSM_EN_FULL   = 4'hF;
   localparam logic [3:0] UPSM_EN_REDUCE = 4'h3;
   localparam logic [3:0] UPSM_EN_NONE   = 4'h0;

   // wake source layout
   localparam int         UPSM_WK_GPIO   = 0;
   localparam int         UPSM_WK_WOL    = 1;
   localparam int         UPSM_WK_LINK   = 2;
   localparam int         UPSM_WK_ENERGY = 3;
   localparam int         UPSM_WK_FRAME  = 4;
   localparam int         UPSM_WK_W      = 5;

   // power state, one-hot
   typedef enum logic [7:0] {
      UPSM_ST_UNPOW  = 8'h01,
      UPSM_ST_UNCFG  = 8'h02,
      UPSM_ST_CFG    = 8'h04,
      UPSM_ST_SUS0   = 8'h08,
      UPSM_ST_SUS1   = 8'h10,
      UPSM_ST_SUS2   = 8'h20,
      UPSM_ST_SUS3   = 8'h40,
      UPSM_ST_SUS2U  = 8'h80
   } upsm_state_t;

endpackage

// ---- core/upsm_power_manager.sv ----
// upsm_power_manager: power state sequencer of a USB network device
// assumes: usb event inputs are one-cycle pulses on i_sys_clk; pins async
`timescale 1ns/100ps

// Functional notes
// - suspend level 2 entered from unconfigured never resumes to configured.
// - bus powered designs tie bus power detect high; unpowered unreachable; reset still enters unpowered until the synced detect rises.
// - power-on without bus power sits unpowered until detect asserts.
// - loss of bus power detect forces unpowered from any state.
// - reset with bus power, or detect rising, enters normal.
// - host resume or enabled wake returns any suspend level to normal.
// - normal starts unconfigured; configure completion makes it configured.
// - host deconfiguration returns to normal unconfigured.
// - configured enables all modules; unconfigured enables a reduced subset.
// - any system reset outside unpowered lands in normal unconfigured.
// - ready bit is set while normal, marking load complete.
// - resume keeps usb context and asserts ready after entering normal.
// - suspend from configured: select 00b gives level 0, 01b level 1.
// - suspend from unconfigured uses level 2, resumes to unconfigured.
// - deconfiguration resets the suspend select field to 10b.
// - usb reset or pin reset in suspend returns to unconfigured.
// - level 0 wakes on wake-on-lan, magic packet or pin events.
// - pin 7 wake keeps a link-up flag telling link from pin.
// - host may resume level 0 or level 1 at any time.
// - level 1 wakes on phy energy detect or pin events.
// - select 10b chooses level 2, the default after reset.
// - level 2 leaves only on host resume, pin wake, usb or pin reset, or bus power loss.
module upsm_power_manager
   import upsm_pkg::*;
#(
   parameter bit HAS_SUS3 = 1'b1
) (
   // clock and reset
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_arst_n,
   // pins, asynchronous
   input  wire logic                 i_bus_power_detect,
   input  wire logic                 i_pin_reset_n,
   input  wire logic                 i_gpio7_link_up,
   // usb device controller events, one-cycle pulses
   input  wire logic                 i_usb_reset,
   input  wire logic                 i_usb_configured,
   input  wire logic                 i_usb_deconfigured,
   input  wire logic                 i_usb_suspend,
   input  wire logic                 i_usb_resume,
   // power_mgmt_control suspend select write
   input  wire logic                 i_sel_wr,
   input  wire logic [1:0]           i_sel_wdata,
   // wake sources, levels from the detection logic
   input  wire logic [UPSM_WK_W-1:0] i_wake_evt,
   input  wire logic [UPSM_WK_W-1:0] i_wake_en,
   // status and enables
   output logic                      o_ready,
   output logic [1:0]                o_suspend_sel,
   output logic [UPSM_EN_W-1:0]      o_module_en,
   output logic                      o_phy_lost,
   output logic                      o_link_up_wake_flag,
   output logic [7:0]                o_state,
   output logic                      o_hw_reinit
);

   ////////////////////////////////////////////////////////////////////
   // input synchronisers

   upsm_sync_if #(.W(3)) pin_if ();

   assign pin_if.raw = {i_bus_power_detect, i_pin_reset_n,
                        i_gpio7_link_up};

   upsm_sync #(
      .W   (3),
      .RST (3'h2)
   ) u_pin_sync (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .s         (pin_if)
   );

   logic bus_pwr;
   logic pin_rst_n;
   logic link_up;

   assign bus_pwr   = pin_if.sync[2];
   assign pin_rst_n = pin_if.sync[1];
   assign link_up   = pin_if.sync[0];

   ////////////////////////////////////////////////////////////////////
   // decode

   upsm_state_t   state_reg;
   upsm_state_t   state_next;
   logic [1:0]    sel_reg;
   logic [1:0]    sel_next;
   logic          link_flag_reg;
   logic          link_flag_next;
   logic          reinit_reg;

   logic          in_normal;
   logic          in_suspend;
   logic          pin_rst_fall;
   logic          sys_reset;
   logic [UPSM_WK_W-1:0] wk_live;
   logic          wake_l0;
   logic          wake_l1;
   logic          wake_l2;
   logic          wake_l3;
   logic          sel_l3_ok;

   assign in_normal  = (state_reg == UPSM_ST_UNCFG) ||
                       (state_reg == UPSM_ST_CFG);
   assign in_suspend = (state_reg == UPSM_ST_SUS0)  ||
                       (state_reg == UPSM_ST_SUS1)  ||
                       (state_reg == UPSM_ST_SUS2)  ||
                       (state_reg == UPSM_ST_SUS3)  ||
                       (state_reg == UPSM_ST_SUS2U);

   // pin reset acts on its falling edge and while held low
   assign pin_rst_fall = !pin_rst_n;
   assign sys_reset    = i_usb_reset || pin_rst_fall;
   assign wk_live      = i_wake_evt & i_wake_en;

   assign wake_l0 = wk_live[UPSM_WK_GPIO] || wk_live[UPSM_WK_WOL] ||
                    wk_live[UPSM_WK_LINK];
   assign wake_l1 = wk_live[UPSM_WK_GPIO] || wk_live[UPSM_WK_ENERGY];
   // level 2 wakes on pins only
   assign wake_l2 = wk_live[UPSM_WK_GPIO];
   assign wake_l3 = wk_live[UPSM_WK_GPIO] || wk_live[UPSM_WK_LINK] ||
                    wk_live[UPSM_WK_FRAME];
   assign sel_l3_ok = HAS_SUS3;

   ////////////////////////////////////////////////////////////////////
   // state machine

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         UPSM_ST_UNPOW: begin
            if (bus_pwr) begin
               state_next = UPSM_ST_UNCFG;
            end
         end
         UPSM_ST_UNCFG: begin
            if (i_usb_configured) begin
               state_next = UPSM_ST_CFG;
            // suspend from unconfigured uses level 2
            end else if (i_usb_suspend) begin
               state_next = UPSM_ST_SUS2U;
            end
         end
         UPSM_ST_CFG: begin
            if (i_usb_deconfigured) begin
               state_next = UPSM_ST_UNCFG;
            end else if (i_usb_suspend) begin
               unique case (sel_reg)
                  UPSM_SEL_L0: state_next = UPSM_ST_SUS0;
                  UPSM_SEL_L1: state_next = UPSM_ST_SUS1;
                  UPSM_SEL_L2: state_next = UPSM_ST_SUS2;
                  UPSM_SEL_L3: state_next = sel_l3_ok ? UPSM_ST_SUS3
                                                      : UPSM_ST_SUS2;
               endcase
            end
         end
         // resume or enabled wake returns to normal
         // host resume accepted at any time
         // usb context kept, configured state restored; level 2 entered from unconfigured restores unconfigured
         UPSM_ST_SUS0: begin
            if (i_usb_resume || wake_l0) begin
               state_next = UPSM_ST_CFG;
            end
         end
         UPSM_ST_SUS1: begin
            if (i_usb_resume || wake_l1) begin
               state_next = UPSM_ST_CFG;
            end
         end
         UPSM_ST_SUS2: begin
            if (i_usb_resume || wake_l2) begin
               state_next = UPSM_ST_CFG;
            end
         end
         UPSM_ST_SUS3: begin
            if (i_usb_resume || wake_l3) begin
               state_next = UPSM_ST_CFG;
            end
         end
         UPSM_ST_SUS2U: begin
            // never back to configured from here
            if (i_usb_resume || wake_l2) begin
               state_next = UPSM_ST_UNCFG;
            end
         end
         default: state_next = UPSM_ST_UNCFG;
      endcase
      if (sys_reset && state_reg != UPSM_ST_UNPOW) begin
         state_next = UPSM_ST_UNCFG;
      end
      // tied high when bus powered, so taken only while the synced detect is still low after reset
      if (!bus_pwr) begin
         state_next = UPSM_ST_UNPOW;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // suspend select field

   always_comb begin
      sel_next = sel_reg;
      if (i_sel_wr) begin
         sel_next = i_sel_wdata;
      end
      // deconfiguration forces 10b, overriding a same-cycle write
      if ((state_reg == UPSM_ST_CFG && state_next == UPSM_ST_UNCFG) ||
          sys_reset) begin
         sel_next = UPSM_SEL_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link-up wake flag: set wins over clear

   always_comb begin
      link_flag_next = link_flag_reg;
      // entering a new suspend from configured starts the record afresh
      if (state_reg == UPSM_ST_CFG && state_next != UPSM_ST_CFG &&
          state_next != UPSM_ST_UNCFG && state_next != UPSM_ST_UNPOW) begin
         link_flag_next = 1'b0;
      end
      // pin 7 wake due to link-up is recorded
      if (in_suspend && wk_live[UPSM_WK_GPIO] && link_up &&
          i_wake_en[UPSM_WK_LINK]) begin
         link_flag_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // power-on starts unpowered until detect is seen
         state_reg     <= UPSM_ST_UNPOW;
         sel_reg       <= UPSM_SEL_RST;
         link_flag_reg <= 1'b0;
         reinit_reg    <= 1'b0;
      end else begin
         state_reg     <= state_next;
         sel_reg       <= sel_next;
         link_flag_reg <= link_flag_next;
         reinit_reg    <= sys_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // ready rises in the same cycle the state register enters normal
   assign o_ready = in_normal;

   assign o_module_en = (state_reg == UPSM_ST_CFG)   ? UPSM_EN_FULL   :
                        (state_reg == UPSM_ST_UNCFG) ? UPSM_EN_REDUCE :
                        UPSM_EN_NONE;

   // phy contents lost after level 2
   assign o_phy_lost          = (state_reg == UPSM_ST_SUS2) ||
                                (state_reg == UPSM_ST_SUS2U);
   // select only read when suspend arrives
   assign o_suspend_sel       = sel_reg;
   assign o_link_up_wake_flag = link_flag_reg;
   assign o_state             = state_reg;
   assign o_hw_reinit         = reinit_reg;

endmodule

// ---- core/upsm_sync.sv ----
// upsm_sync: two flip-flop level synchroniser for asynchronous inputs
// assumes: inputs are levels, held for several clock periods
`timescale 1ns/100ps
module upsm_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_arst_n,
   // levels
   upsm_sync_if.dst  s
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_reg <= RST;
         sync_reg <= RST;
      end else begin
         meta_reg <= s.raw;
         sync_reg <= meta_reg;
      end
   end

   assign s.sync = sync_reg;
endmodule

// ---- core/upsm_sync_if.sv ----
// upsm_sync_if: carries the raw and synchronised input levels
// assumes: driven from the power manager top, read by its synchroniser
`timescale 1ns/100ps
interface upsm_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface
